// ===== tcp_channel_ctrl.sv
// Timer channel pair control: flags, modes, compare/capture and buffered PWM.
`timescale 1ns/1ps
`default_nettype none

module tcp_channel_ctrl
    import tcp_pkg::*;
(
    input  wire logic             clk_in,          // Bus clock, 250 MHz.
    input  wire logic             nrst_in,         // Asynchronous active-low reset.
    input  wire logic             wb_cyc_in,       // Wishbone cycle.
    input  wire logic             wb_stb_in,       // Wishbone strobe.
    input  wire logic             wb_we_in,        // Wishbone write enable.
    input  wire logic [7:0]       wb_adr_in,       // Wishbone byte address.
    input  wire logic [3:0]       wb_sel_in,       // Wishbone byte lane selects.
    input  wire logic [31:0]      wb_dat_in,       // Wishbone write data.
    output logic      [31:0]      wb_dat_out,      // Wishbone read data.
    output logic                  wb_ack_out,      // Wishbone acknowledge.
    input  wire logic [CNT_W-1:0] cnt_value_in,    // Shared timer counter value.
    input  wire logic             cnt_step_in,     // Pulse: counter took a new value.
    input  wire logic             ovf_in,          // Pulse: counter overflow, end of period.
    input  wire logic [1:0]       chan_pin_in,     // Channel pin levels from the pads.
    output logic      [1:0]       chan_pin_out,    // Channel pin drive levels.
    output logic      [1:0]       chan_pin_oe_out, // Channel pin drive enables, high drives.
    output logic      [1:0]       chan_irq_out,    // Channel interrupt requests to the CPU.
    output logic                  buf_active_out   // Channel whose value sets the linked width.
);

    // Register state.
    tcp_sc_t          sc_reg   [2];  // Status and control bytes.
    tcp_sc_t          sc_next  [2];
    logic [CNT_W-1:0] cmp_reg  [2];  // Compare or capture values.
    logic [CNT_W-1:0] cmp_next [2];
    logic [1:0]       arm_reg;       // Flag was read while set; a zero write may clear it.
    logic [1:0]       arm_next;
    logic [1:0]       pin_reg;       // Compare output levels.
    logic [1:0]       pin_next;
    logic             active_reg;    // Linked pair: channel now in control.
    logic             active_next;
    logic             last_wr_reg;   // Linked pair: channel written most recently.
    logic             last_wr_next;
    tcp_bus_state_t   bus_state_reg; // Bus slave state.
    tcp_bus_state_t   bus_state_next;
    logic [31:0]      rdata_reg;     // Registered read data.
    logic [31:0]      rdata_next;

    // Synchronised pin edges.
    logic [1:0] pin_level;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;

    // Decoded per-cycle conditions.
    logic             acc;           // A bus request is taken this cycle.
    logic             wr;            // Taken request is a write.
    logic             rd;            // Taken request is a read.
    logic             linked;        // Channels 0 and 1 form one buffered channel.
    logic [1:0]       ch_on;         // Channel is in service.
    logic [1:0]       is_cmp;        // Channel works in compare/PWM mode.
    logic [1:0]       match;         // Compare match this cycle.
    logic [1:0]       capture;       // Capture edge this cycle.
    logic [CNT_W-1:0] cmp_eff  [2];  // Compare value the channel actually uses.

    // One synchroniser per channel pin; pins come from outside the clock domain.
    // The synchroniser adds latency, so a capture lands a few cycles after
    // the pin changes; the captured counter value reflects that delay.
    for (genvar g = 0; g < 2; g++) begin : g_sync
        tcp_pin_sync u_sync (
            .clk_in    (clk_in),
            .nrst_in   (nrst_in),
            .pin_in    (chan_pin_in[g]),
            .level_out (pin_level[g]),
            .rise_out  (pin_rise[g]),
            .fall_out  (pin_fall[g])
        );
    end

    // Mode decode and event detection for both channels.
    always_comb begin
        acc    = wb_cyc_in & wb_stb_in & (bus_state_reg == BUS_IDLE);
        wr     = acc & wb_we_in;
        rd     = acc & ~wb_we_in;
        linked = sc_reg[0].buf_mode;
        // A linked pair takes channel 1 out of service.
        ch_on  = {~linked, 1'b1};
        // Linked channel 0 is always in compare mode; otherwise mode bit A decides.
        is_cmp[0] = sc_reg[0].mode_a | linked;
        is_cmp[1] = sc_reg[1].mode_a;
        // Linked channel 0 compares against whichever register set is active.
        cmp_eff[0] = (linked && active_reg) ? cmp_reg[1] : cmp_reg[0];
        cmp_eff[1] = cmp_reg[1];
        for (int i = 0; i < 2; i++) begin
            // Only exact equality on a counter step matches, so a value the counter
            // already passed gives no match until it comes round again.
            match[i] = ch_on[i] & is_cmp[i] & cnt_step_in
                     & (cnt_value_in == cmp_eff[i]);
            // Capture edges follow the edge/level select.
            capture[i] = ch_on[i] & ~is_cmp[i]
                       & ((sc_reg[i].edge_level[0] & pin_rise[i])
                        | (sc_reg[i].edge_level[1] & pin_fall[i]));
        end
    end

    // Status and control, flags and compare registers.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            sc_next[i]  = sc_reg[i];
            cmp_next[i] = cmp_reg[i];
            arm_next[i] = arm_reg[i];
        end
        last_wr_next = last_wr_reg;
        for (int i = 0; i < 2; i++) begin
            // Reading the control byte while the flag is set arms the clear.
            if (rd && wb_adr_in == (i == 0 ? ADDR_SC0 : ADDR_SC1) && ch_on[i] && sc_reg[i].flag) begin
                arm_next[i] = 1'b1;
            end
            // Control byte write; channel 1 ignores writes while linked.
            if (wr && wb_sel_in[0] && wb_adr_in == (i == 0 ? ADDR_SC0 : ADDR_SC1) && ch_on[i]) begin
                sc_next[i].irq_en     = wb_dat_in[IE_BIT];
                sc_next[i].mode_a     = wb_dat_in[MSA_BIT];
                sc_next[i].edge_level = wb_dat_in[MSA_BIT-1:MSA_BIT-2];
                sc_next[i].tov        = wb_dat_in[TOV_BIT];
                // The link bit exists only in channel 0.
                sc_next[i].buf_mode   = (i == 0) ? wb_dat_in[BUF_BIT] : 1'b0;
                // A zero clears only after an armed read; a one is ignored.
                if (!wb_dat_in[FLAG_BIT] && arm_reg[i]) begin
                    sc_next[i].flag = 1'b0;
                end
                arm_next[i] = 1'b0;
            end
            // Compare register write simply overwrites; there is no shadow copy,
            // so an unsynchronised write can upset up to two periods.
            if (wr && wb_adr_in == (i == 0 ? ADDR_CMP0 : ADDR_CMP1)) begin
                if (wb_sel_in[0]) begin
                    cmp_next[i][7:0] = wb_dat_in[7:0];
                end
                if (wb_sel_in[1]) begin
                    cmp_next[i][CNT_W-1:8] = wb_dat_in[CNT_W-1:8];
                end
                if (|wb_sel_in[1:0]) begin
                    last_wr_next = (i == 1);
                end
            end
            // Capture latches the counter.
            if (capture[i]) begin
                cmp_next[i] = cnt_value_in;
            end
            // A new event sets the flag and drops the armed read, so a zero
            // written afterwards, or in the same cycle, leaves the flag set.
            if (match[i] || capture[i]) begin
                sc_next[i].flag = 1'b1;
                arm_next[i]     = 1'b0;
            end
        end
        // Unlinked, the pair history restarts so channel 0 leads after linking.
        // The incoming link bit is used as well, so that the history is dropped
        // at the same edge as the unlinking write and never lags it by a cycle.
        if (!linked || !sc_next[0].buf_mode) begin
            last_wr_next = 1'b0;
        end
    end

    // Active channel of the pair changes only at overflow, so a width takes
    // effect from the start of the next period.
    // Unlinking clears the active channel at the edge that takes the write,
    // so a stale selection can never leak into the next linked session.
    // Software that relinks therefore always starts from the channel 0 values.
    // The trade-off is that the pair history is lost on every unlink.
    always_comb begin
        active_next = active_reg;
        if (!linked || !sc_next[0].buf_mode) begin
            active_next = 1'b0;
        end else if (ovf_in) begin
            active_next = last_wr_reg;
        end
    end

    // Pin output levels: overflow toggle first, a compare in the same cycle then acts on the toggled level.
    always_comb begin
        pin_next = pin_reg;
        for (int i = 0; i < 2; i++) begin
            if (ovf_in && sc_reg[i].tov && ch_on[i] && is_cmp[i]) begin
                pin_next[i] = ~pin_reg[i];
            end
            if (match[i]) begin
                case (sc_reg[i].edge_level)
                    ELS_RISE: pin_next[i] = ~pin_next[i];
                    ELS_FALL: pin_next[i] = 1'b0;
                    ELS_BOTH: pin_next[i] = 1'b1;
                    default:  pin_next[i] = pin_next[i];
                endcase
            end
        end
    end

    // Bus slave: take a request, answer with ack in the next cycle.
    always_comb begin
        bus_state_next = BUS_IDLE;
        rdata_next     = rdata_reg;
        case (bus_state_reg)
            BUS_IDLE: begin
                if (acc) begin
                    bus_state_next = BUS_ACK;
                    // Unmapped addresses answer with zero.
                    case (wb_adr_in)
                        ADDR_SC0:  rdata_next = {24'h000000, sc_reg[0]};
                        ADDR_CMP0: rdata_next = {16'h0000, cmp_reg[0]};
                        ADDR_SC1:  rdata_next = {24'h000000, sc_reg[1]};
                        ADDR_CMP1: rdata_next = {16'h0000, cmp_reg[1]};
                        ADDR_STAT: rdata_next = {30'h00000000, last_wr_reg, active_reg};
                        default:   rdata_next = 32'h00000000;
                    endcase
                end
            end
            BUS_ACK: begin
                // The ack lasts one cycle; the master must drop its strobe.
                bus_state_next = BUS_IDLE;
            end
            default: begin
                bus_state_next = BUS_IDLE;
            end
        endcase
    end

    // Register everything; reset clears flags, enables and the link bit.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < 2; i++) begin
                sc_reg[i]  <= SC_RESET;
                cmp_reg[i] <= CMP_RESET;
            end
            arm_reg       <= 2'h0;
            pin_reg       <= 2'h0;
            active_reg    <= 1'b0;
            last_wr_reg   <= 1'b0;
            bus_state_reg <= BUS_IDLE;
            rdata_reg     <= 32'h00000000;
        end else begin
            for (int i = 0; i < 2; i++) begin
                sc_reg[i]  <= sc_next[i];
                cmp_reg[i] <= cmp_next[i];
            end
            arm_reg       <= arm_next;
            pin_reg       <= pin_next;
            active_reg    <= active_next;
            last_wr_reg   <= last_wr_next;
            bus_state_reg <= bus_state_next;
            rdata_reg     <= rdata_next;
        end
    end

    // Outputs. The linked output appears on channel 0; channel 1 is released
    // to general-purpose use and its request is held off.
    assign wb_dat_out      = rdata_reg;
    assign wb_ack_out      = (bus_state_reg == BUS_ACK);
    assign chan_pin_out    = pin_reg;
    assign chan_pin_oe_out = {ch_on[1] & is_cmp[1] & (sc_reg[1].edge_level != ELS_OFF),
                              is_cmp[0] & (sc_reg[0].edge_level != ELS_OFF)};
    assign chan_irq_out    = {ch_on[1] & sc_reg[1].flag & sc_reg[1].irq_en,
                              sc_reg[0].flag & sc_reg[0].irq_en};
    assign buf_active_out  = active_reg;

endmodule : tcp_channel_ctrl

`default_nettype wire

// ===== tcp_pkg.sv
// Shared constants, field layout and types for the timer channel PWM control block.
`default_nettype none

package tcp_pkg;

    // Width of the shared timer counter and of each channel compare register.
    localparam int CNT_W = 16;

    // Wishbone byte addresses of the registers, one aligned word each.
    localparam logic [7:0] ADDR_SC0  = 8'h00;  // Channel 0 status and control.
    localparam logic [7:0] ADDR_CMP0 = 8'h04;  // Channel 0 compare or capture value.
    localparam logic [7:0] ADDR_SC1  = 8'h08;  // Channel 1 status and control.
    localparam logic [7:0] ADDR_CMP1 = 8'h0C;  // Channel 1 compare or capture value.
    localparam logic [7:0] ADDR_STAT = 8'h10;  // Buffered pair state, read only.

    // Bit positions inside the status and control byte.
    localparam int FLAG_BIT = 7;
    localparam int IE_BIT   = 6;
    localparam int BUF_BIT  = 5;
    localparam int MSA_BIT  = 4;
    localparam int TOV_BIT  = 1;

    // Edge/level select encodings.
    localparam logic [1:0] ELS_OFF  = 2'h0;  // Pin not used by the channel.
    localparam logic [1:0] ELS_RISE = 2'h1;  // Capture rising edge, or toggle on compare.
    localparam logic [1:0] ELS_FALL = 2'h2;  // Capture falling edge, or clear on compare.
    localparam logic [1:0] ELS_BOTH = 2'h3;  // Capture both edges, or set on compare.

    // Layout of the status and control byte.
    typedef struct packed {
        logic       flag;        // Channel event flag.
        logic       irq_en;      // Channel interrupt enable.
        logic       buf_mode;    // Pair link select, channel 0 only.
        logic       mode_a;      // 1 compare/PWM, 0 input capture.
        logic [1:0] edge_level;  // Edge/level select.
        logic       tov;         // Toggle pin on counter overflow.
        logic       rsvd;        // Reserved, reads zero.
    } tcp_sc_t;

    // Reset values.
    localparam tcp_sc_t        SC_RESET  = 8'h00;
    localparam logic [CNT_W-1:0] CMP_RESET = 16'hFFFF;

    // Bus slave state: idle, or answering in this cycle.
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } tcp_bus_state_t;

endpackage : tcp_pkg

`default_nettype wire

// ===== tcp_pin_sync.sv
// Two-stage pin synchroniser with edge detection for one channel pin.
`timescale 1ns/1ps
`default_nettype none

module tcp_pin_sync
    import tcp_pkg::*;
(
    input  wire logic clk_in,    // Bus clock.
    input  wire logic nrst_in,   // Asynchronous active-low reset.
    input  wire logic pin_in,    // Raw pin level from outside the clock domain.
    output logic      level_out, // Synchronised level.
    output logic      rise_out,  // One-cycle pulse on a rising edge.
    output logic      fall_out   // One-cycle pulse on a falling edge.
);

    logic meta_reg;   // First stage, read only by the second stage.
    logic sync_reg;   // Second stage, safe to use.
    logic prev_reg;   // Previous synchronised level for edge detection.
    logic meta_next;
    logic sync_next;
    logic prev_next;

    // Next values of the three stages.
    always_comb begin
        meta_next = pin_in;
        sync_next = meta_reg;
        prev_next = sync_reg;
    end

    // Register the stages; reset leaves the pin seen as low with no edge.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
        end
    end

    // Edges are taken only from the second and third stages.
    assign level_out = sync_reg;
    assign rise_out  = sync_reg & ~prev_reg;
    assign fall_out  = ~sync_reg & prev_reg;

endmodule : tcp_pin_sync

`default_nettype wire

// ===== tcp_channel_ctrl_asserts.sv
// Concurrent checks on the ports of the timer channel PWM control block.
`timescale 1ns/1ps
`default_nettype none

module tcp_channel_ctrl_asserts
    import tcp_pkg::*;
(
    input wire logic             clk_in,
    input wire logic             nrst_in,
    input wire logic             wb_cyc_in,
    input wire logic             wb_stb_in,
    input wire logic             wb_we_in,
    input wire logic [7:0]       wb_adr_in,
    input wire logic [3:0]       wb_sel_in,
    input wire logic [31:0]      wb_dat_in,
    input wire logic [31:0]      wb_dat_out,
    input wire logic             wb_ack_out,
    input wire logic             ovf_in,
    input wire logic [1:0]       chan_pin_oe_out,
    input wire logic [1:0]       chan_irq_out,
    input wire logic             buf_active_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    logic take;      // A request is taken at this edge.
    logic wr_sc0;    // A channel 0 control write is taken at this edge.
    logic unmapped;  // The taken request hits no register.
    logic link_reg;  // Shadow of the pair link bit, kept from the bus writes.
    logic link_next; // Next shadow link bit.
    logic ie0_reg;   // Shadow of the channel 0 interrupt enable.
    logic ie0_next;  // Next shadow enable.

    assign take     = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign wr_sc0   = take && wb_we_in && wb_sel_in[0] && (wb_adr_in == ADDR_SC0);
    assign unmapped = !(wb_adr_in inside {ADDR_SC0, ADDR_CMP0, ADDR_SC1, ADDR_CMP1, ADDR_STAT});

    // The shadows follow only taken writes, so they mirror the real bits exactly.
    always_comb begin
        link_next = wr_sc0 ? wb_dat_in[BUF_BIT] : link_reg;
        ie0_next  = wr_sc0 ? wb_dat_in[IE_BIT] : ie0_reg;
    end

    // Shadow registers, cleared with the design.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            link_reg <= 1'b0;
            ie0_reg  <= 1'b0;
        end else begin
            link_reg <= link_next;
            ie0_reg  <= ie0_next;
        end
    end

    sequence s_taken;
        take;
    endsequence
    sequence s_answer;
        wb_ack_out ##1 !wb_ack_out;
    endsequence

    a_ack_after_take: assert property (s_taken |=> s_answer) else $error("ack missing or too long");
    a_no_stray_ack: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out) else $error("ack without request");
    a_unmapped_reads_zero: assert property (take && !wb_we_in && unmapped |=> wb_dat_out == 32'h0)
        else $error("unmapped read not zero");
    a_linked_ch1_off: assert property (link_reg |-> chan_pin_oe_out[1] == 1'b0 && chan_irq_out[1] == 1'b0)
        else $error("channel 1 active while linked");
    a_active_unlinked: assert property (!link_reg |-> !buf_active_out) else $error("active set while unlinked");
    a_active_on_ovf: assert property (buf_active_out != $past(buf_active_out) |-> $past(ovf_in) || !link_reg)
        else $error("active channel moved without overflow");
    a_irq_needs_en: assert property (chan_irq_out[0] |-> ie0_reg) else $error("irq without enable");
    a_irq_flag_sticky: assert property (chan_irq_out[0] && !wr_sc0 |=> chan_irq_out[0])
        else $error("flag cleared without write");
endmodule : tcp_channel_ctrl_asserts

bind tcp_channel_ctrl tcp_channel_ctrl_asserts i_tcp_channel_ctrl_asserts (.clk_in(clk_in), .nrst_in(nrst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .ovf_in(ovf_in), .chan_pin_oe_out(chan_pin_oe_out), .chan_irq_out(chan_irq_out),
    .buf_active_out(buf_active_out));

`default_nettype wire

// ===== tcp_channel_ctrl_tb_top.sv
// Self-checking testbench for the timer channel PWM control block.
`timescale 1ns/1ps
`default_nettype none

module tcp_channel_ctrl_tb_top
    import tcp_pkg::*;
;
    logic             clk_in = 1'b0;  // 250 MHz bus clock.
    logic             nrst_in = 1'b0; // Active-low reset.
    logic             cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, step = 1'b0, ovf = 1'b0, active;
    logic [7:0]       adr = 8'h00;
    logic [3:0]       sel = 4'h0;
    logic [31:0]      wdat = 32'h0, rdat, q;
    logic [CNT_W-1:0] cnt = 16'h0000;
    logic [1:0]       pin_in = 2'h0, pin_out, pin_oe, irq;
    int               error_cnt = 0;
    int               n_tests = 0;

    always #2 clk_in = ~clk_in;

    tcp_channel_ctrl i_tcp_channel_ctrl (.clk_in(clk_in), .nrst_in(nrst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .cnt_value_in(cnt), .cnt_step_in(step), .ovf_in(ovf), .chan_pin_in(pin_in), .chan_pin_out(pin_out),
        .chan_pin_oe_out(pin_oe), .chan_irq_out(irq), .buf_active_out(active));

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // Compares one value; a mismatch is reported at once.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One classic Wishbone cycle; the request holds until ack is sampled high.
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_in);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
        do @(posedge clk_in); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0, q);
        chk(name, exp, q);
    endtask : rd_chk

    // One counter step to value v; the flag lands at the step edge and has
    // settled by the following edge, at which the task returns.
    task automatic cstep(input logic [15:0] v);
        @(posedge clk_in);
        cnt <= v; step <= 1'b1;
        @(posedge clk_in);
        step <= 1'b0;
        @(posedge clk_in);
    endtask : cstep

    // A hang counts as a mismatch and ends the run through the same task.
    initial begin
        repeat (5000) @(posedge clk_in);
        error_cnt++;
        complete_run();
    end

    initial begin
        repeat (20) @(posedge clk_in);
        nrst_in <= 1'b1;
        rd_chk("sc0 reset", ADDR_SC0, 32'h0);
        rd_chk("cmp0 reset", ADDR_CMP0, 32'h0000FFFF);
        rd_chk("unmapped", 8'h14, 32'h0);
        wr(ADDR_SC0, 32'hDC);                                       // Writing the flag as one is ignored.
        rd_chk("sc0 cfg", ADDR_SC0, 32'h5C);
        chk("ch0 oe", 32'h1, pin_oe[0]);
        wr(ADDR_CMP0, 32'h0010);
        cstep(16'h0011);
        chk("no match past", 32'h0, irq);
        cstep(16'h0010);
        chk("match irq", 32'h1, irq);
        chk("set on match", 32'h1, pin_out[0]);
        wr(ADDR_SC0, 32'h5C);
        chk("zero write unarmed", 32'h1, irq);
        rd_chk("sc0 flag", ADDR_SC0, 32'hDC);
        cstep(16'h0010);
        wr(ADDR_SC0, 32'h5C);
        chk("event between", 32'h1, irq);
        rd_chk("sc0 arm", ADDR_SC0, 32'hDC);
        wr(ADDR_SC0, 32'h5C);
        chk("flag cleared", 32'h0, irq);
        wr(ADDR_SC0, 32'h1C);
        cstep(16'h0010);
        chk("irq masked", 32'h0, irq);
        rd_chk("sc0 masked flag", ADDR_SC0, 32'h9C);
        wr(ADDR_SC0, 32'h1C);
        wr(ADDR_SC1, 32'h18);
        chk("ch1 oe", 32'h1, pin_oe[1]);
        wr(ADDR_SC0, 32'h38);                                       // Link the pair, clear on match.
        chk("ch1 released", 32'h0, pin_oe[1]);
        rd_chk("pair start", ADDR_STAT, 32'h0);
        wr(ADDR_SC1, 32'h54);
        rd_chk("sc1 ignored", ADDR_SC1, 32'h18);
        wr(ADDR_CMP1, 32'h0020);
        chk("no early swap", 32'h0, active);
        @(posedge clk_in) ovf <= 1'b1;
        @(posedge clk_in) ovf <= 1'b0;
        @(posedge clk_in);
        chk("swap at ovf", 32'h1, active);
        rd_chk("pair state", ADDR_STAT, 32'h3);
        cstep(16'h0020);
        chk("linked out", 32'h0, pin_out[0]);
        rd_chk("sc0 linked flag", ADDR_SC0, 32'hB8);
        wr(ADDR_SC0, 32'h00);
        wr(ADDR_SC1, 32'h04);                                       // Capture on rising edge.
        @(posedge clk_in) begin cnt <= 16'h0123; pin_in <= 2'h2; end
        repeat (8) @(posedge clk_in);
        rd_chk("capture value", ADDR_CMP1, 32'h0123);
        rd_chk("capture flag", ADDR_SC1, 32'h84);
        complete_run();
    end
endmodule : tcp_channel_ctrl_tb_top

`default_nettype wire
